/* File: channel_irq_vector_gen.v */
/*
  Channel interrupt vector generator: builds receive and transmit vectors
  from protocol handler and descriptor engine events and offers them one
  at a time toward the interrupt queue writer. AXI4-Lite register slave.
  Assumes all event inputs come from logic on aclk, held until ready.
*/
// Implementation choices: register access over AXI4-Lite and the register offsets.
// Overview of operation
// - Finished receive descriptor with notify flag yields receive notify vector.
// - Second and later stall discards set receive abort and stall abort together.
// - Silent discard applies while descriptor stalls and packets keep arriving.
// - Every discarded packet gets its own discard vector.
// - Frame longer than the channel's maximum length sets the length flag.
// - Failure to move data into receive buffer records overflow for channel.
// - Overflow vector goes out only once the buffer accepts data again.
// - Computed and carried check values differing sets the CRC flag, except on a line-aborted frame.
// - Frame bit count not a multiple of eight sets bad length flag.
// - Transmit vectors carry the tag of the descriptor in use.
// - Finished transmit descriptor with notify flag yields transmit notify vector.
// - Abort or branch command cutting a frame short raises transmit abort.
// - Zero byte count without frame end after incomplete frame raises transmit abort.
// - Fetched stalled descriptor without frame end raises transmit stall abort.
// - Transmit stall abort vector waits until the data section is transferred.
// - After transmit stall abort the protocol machine appends an abort sequence.
// - Transmit vectors carry an eight-bit channel number.
`timescale 1ns/1ps
`include "irq_vector_regs.vh"
module channel_irq_vector_gen #(
  parameter CW = 8,
  parameter LW = 16
) (
  // Clock, reset, enable
  input wire aclk,
  input wire aresetn,
  input wire ce,
  // AXI4-Lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Receive events
  input wire [CW-1:0] rx_channel_number,
  input wire rx_frame_done,
  input wire rx_desc_notify,
  input wire rx_line_abort,
  input wire [LW-1:0] rx_bit_count,
  input wire [15:0] rx_crc_calc,
  input wire [15:0] rx_crc_recv,
  input wire rx_packet_start,
  input wire rx_desc_stall,
  input wire rx_overflow_start,
  input wire rx_buf_can_store,
  output wire rx_ready,
  // Transmit events
  input wire [CW-1:0] tx_channel_number,
  input wire [5:0] tx_desc_id,
  input wire tx_desc_done,
  input wire tx_desc_notify,
  input wire tx_abort_cmd,
  input wire tx_fetch,
  input wire tx_fetch_zero_count,
  input wire tx_fetch_fe,
  input wire tx_fetch_stall,
  input wire tx_prev_incomplete,
  input wire tx_data_done,
  output wire tx_ready,
  output reg tx_append_abort,
  output reg [CW-1:0] tx_append_channel_number,
  // Vector output
  output reg [31:0] vec_data,
  output reg vec_valid,
  input wire vec_ready
);

  // Register state
  reg [31:0] ctrl_reg;
  reg [7:0] aw_addr_reg;
  reg aw_got_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  reg w_got_reg;
  wire en = ctrl_reg[`CTRL_EN_BIT];
  wire [2:0] rx_queue = ctrl_reg[`CTRL_RXQ_LSB+2:`CTRL_RXQ_LSB];
  wire [2:0] tx_queue = ctrl_reg[`CTRL_TXQ_LSB+2:`CTRL_TXQ_LSB];

  // Vector slots
  reg [31:0] rx_slot_reg;
  reg rx_slot_v_reg;
  reg [31:0] disc_slot_reg;
  reg disc_v_reg;
  reg [31:0] tx_slot_reg;
  reg tx_slot_v_reg;
  reg ovf_pend_reg;
  reg [CW-1:0] ovf_channel_number_reg;
  reg swab_pend_reg;
  reg [CW-1:0] swab_channel_number_reg;
  reg [1:0] disc_cnt_reg;
  reg tx_stall_abort_pend_reg;

  // Receive pipeline stage, waits one cycle for the length table
  reg s_v_reg;
  reg [CW-1:0] s_channel_number_reg;
  reg s_notify_reg;
  reg s_abort_reg;
  reg s_crc_reg;
  reg s_bad_bit_length_reg;
  reg [LW-1:0] s_bytes_reg;
  wire [LW-1:0] max_len;

  // Bus write decode
  wire wr_fire = aw_got_reg && w_got_reg && !s_axi_bvalid;
  wire wr_full = (w_strb_reg == 4'hf);
  wire wr_ctrl = wr_fire && aw_addr_reg == `OFS_CTRL;
  wire wr_cmd = wr_fire && aw_addr_reg == `OFS_CMD;
  wire wr_maxlen = wr_fire && aw_addr_reg == `OFS_MAXLEN && wr_full;
  wire wr_count = wr_fire && aw_addr_reg == `OFS_COUNT;
  wire wr_known = wr_ctrl || wr_cmd || wr_maxlen || wr_count;

  assign s_axi_awready = !aw_got_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_got_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // Back-pressure toward the event sources
  assign rx_ready = en && !s_v_reg && !rx_slot_v_reg && !disc_v_reg;
  assign tx_ready = en && !tx_slot_v_reg;

  wire rx_take = ce && rx_ready;
  wire tx_take = ce && tx_ready;

  maxlen_mem #(
    .AW(CW),
    .DW(LW)
  ) u_maxlen (
    .aclk(aclk),
    .ce(ce),
    .we(wr_maxlen),
    .waddr(w_data_reg[`MAXLEN_CHANNEL_NUMBER_LSB+CW-1:`MAXLEN_CHANNEL_NUMBER_LSB]),
    .wdata(w_data_reg[LW-1:0]),
    .raddr(rx_channel_number),
    .rdata(max_len)
  );

  // Upper half of a vector: direction, queue, descriptor tag
  function [15:0] vec_hi;
    input dir;
    input [2:0] queue;
    input [5:0] tag;
    begin
      vec_hi = {dir, 4'h0, queue, 2'b00, tag};
    end
  endfunction

  // Arbiter: fixed priority, receive ahead of transmit
  wire load = ce && (!vec_valid || vec_ready);
  wire ovf_ok = ovf_pend_reg && rx_buf_can_store;
  wire g_rx = load && rx_slot_v_reg;
  wire g_disc = load && !rx_slot_v_reg && disc_v_reg;
  wire g_ovf = load && !rx_slot_v_reg && !disc_v_reg && ovf_ok;
  wire g_swab = load && !rx_slot_v_reg && !disc_v_reg && !ovf_ok && swab_pend_reg;
  wire g_tx = load && !rx_slot_v_reg && !disc_v_reg && !ovf_ok && !swab_pend_reg && tx_slot_v_reg;
  wire g_any_rx = g_rx || g_disc || g_ovf || g_swab;

  reg [31:0] sel_vec;
  // Select the granted vector
  always @* begin
    sel_vec = 32'h0000_0000;
    if (g_rx) begin
      sel_vec = rx_slot_reg;
    end else if (g_disc) begin
      sel_vec = disc_slot_reg;
    end else if (g_ovf) begin
      sel_vec = {vec_hi(1'b0, rx_queue, 6'h00), 8'h00, ovf_channel_number_reg};
      sel_vec[`V_OVF] = 1'b1;
    end else if (g_swab) begin
      sel_vec = {vec_hi(1'b0, rx_queue, 6'h00), 8'h00, swab_channel_number_reg};
      sel_vec[`V_ABORT] = 1'b1;
    end else if (g_tx) begin
      sel_vec = tx_slot_reg;
    end
  end

  // Transmit event decode, all events belong to the descriptor in use
  wire tx_zero_abort = tx_fetch && tx_fetch_zero_count && !tx_fetch_fe && tx_prev_incomplete;
  wire tx_hold_fetch = tx_fetch && tx_fetch_stall && !tx_fetch_fe;
  wire tx_tx_stall_abort_now = tx_data_done && (tx_stall_abort_pend_reg || tx_hold_fetch);
  wire tx_thi_now = tx_desc_done && tx_desc_notify;
  wire tx_tab_now = tx_abort_cmd || tx_zero_abort;
  wire tx_any = tx_thi_now || tx_tab_now || tx_tx_stall_abort_now;

  // Receive frame end and packet start checks
  wire [LW-1:0] bytes_now = {3'b000, rx_bit_count[LW-1:3]};
  wire disc_now = rx_packet_start && rx_desc_stall;

  // AXI write channel capture and response
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      ctrl_reg <= `CTRL_RESET;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
        if (wr_ctrl) begin
          ctrl_reg <= w_data_reg & 32'h0000_7701;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  wire [15:0] rx_count;
  wire [15:0] tx_count;
  reg [31:0] rd_next;
  // Read decode; unmapped offsets answer zero with an error
  always @* begin
    case ({s_axi_araddr[7:2], 2'b00})
      `OFS_CTRL: rd_next = ctrl_reg;
      `OFS_CMD: rd_next = {23'h000000, swab_pend_reg, swab_channel_number_reg};
      `OFS_MAXLEN: rd_next = 32'h0000_0000;
      `OFS_COUNT: rd_next = {tx_count, rx_count};
      `OFS_PENDING: rd_next = {26'h0000000, disc_cnt_reg, tx_stall_abort_pend_reg, ovf_pend_reg, tx_slot_v_reg,
        rx_slot_v_reg};
      default: rd_next = 32'h0000_0000;
    endcase
  end

  wire rd_known = ({s_axi_araddr[7:2], 2'b00} <= `OFS_PENDING);

  // AXI read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_next;
        s_axi_rresp <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Receive path: stage, slot, discard, overflow, software abort
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_v_reg <= 1'b0;
      s_channel_number_reg <= {CW{1'b0}};
      s_notify_reg <= 1'b0;
      s_abort_reg <= 1'b0;
      s_crc_reg <= 1'b0;
      s_bad_bit_length_reg <= 1'b0;
      s_bytes_reg <= {LW{1'b0}};
      rx_slot_reg <= 32'h0000_0000;
      rx_slot_v_reg <= 1'b0;
      disc_slot_reg <= 32'h0000_0000;
      disc_v_reg <= 1'b0;
      disc_cnt_reg <= 2'b00;
      ovf_pend_reg <= 1'b0;
      ovf_channel_number_reg <= {CW{1'b0}};
      swab_pend_reg <= 1'b0;
      swab_channel_number_reg <= {CW{1'b0}};
    end else if (ce) begin
      s_v_reg <= 1'b0;
      if (rx_take && rx_frame_done) begin
        s_v_reg <= 1'b1;
        s_channel_number_reg <= rx_channel_number;
        s_notify_reg <= rx_desc_notify;
        s_abort_reg <= rx_line_abort;
        s_crc_reg <= !rx_line_abort && (rx_crc_calc != rx_crc_recv);
        s_bad_bit_length_reg <= (rx_bit_count[2:0] != 3'b000);
        s_bytes_reg <= bytes_now;
      end
      if (g_rx) begin
        rx_slot_v_reg <= 1'b0;
      end
      // Length table answers now, so the vector is complete
      if (s_v_reg) begin
        rx_slot_v_reg <= 1'b1;
        rx_slot_reg <= {vec_hi(1'b0, rx_queue, 6'h00), s_notify_reg, s_abort_reg, !s_abort_reg, 1'b0,
          (s_bytes_reg > max_len), 1'b0, s_crc_reg, s_bad_bit_length_reg, s_channel_number_reg};
      end
      // One vector per dropped packet; the second drop onward is a silent discard
      if (!rx_desc_stall) begin
        disc_cnt_reg <= 2'b00;
      end
      if (g_disc) begin
        disc_v_reg <= 1'b0;
      end
      if (rx_take && disc_now) begin
        disc_v_reg <= 1'b1;
        disc_slot_reg <= {vec_hi(1'b0, rx_queue, 6'h00), 1'b0, (disc_cnt_reg != 2'b00), 1'b0, 1'b1,
          4'h0, rx_channel_number};
        if (disc_cnt_reg != 2'b11) begin
          disc_cnt_reg <= disc_cnt_reg + 2'b01;
        end
      end
      // Overflow held until the buffer drains; a new start wins over a grant
      if (g_ovf) begin
        ovf_pend_reg <= 1'b0;
      end
      if (en && rx_overflow_start) begin
        ovf_pend_reg <= 1'b1;
        ovf_channel_number_reg <= rx_channel_number;
      end
      // Software abort command, set wins over the grant
      if (g_swab) begin
        swab_pend_reg <= 1'b0;
      end
      if (wr_cmd && w_data_reg[`CMD_ABORT_BIT]) begin
        swab_pend_reg <= 1'b1;
        swab_channel_number_reg <= w_data_reg[CW-1:0];
      end
    end
  end

  // Transmit path: event merge into one slot and stall abort tracking
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_slot_reg <= 32'h0000_0000;
      tx_slot_v_reg <= 1'b0;
      tx_stall_abort_pend_reg <= 1'b0;
      tx_append_abort <= 1'b0;
      tx_append_channel_number <= {CW{1'b0}};
    end else if (ce) begin
      tx_append_abort <= 1'b0;
      if (g_tx) begin
        tx_slot_v_reg <= 1'b0;
      end
      if (tx_take) begin
        if (tx_hold_fetch && !tx_data_done) begin
          tx_stall_abort_pend_reg <= 1'b1;
        end else if (tx_data_done) begin
          tx_stall_abort_pend_reg <= 1'b0;
        end
        if (tx_any) begin
          tx_slot_v_reg <= 1'b1;
          tx_slot_reg <= {vec_hi(1'b1, tx_queue, tx_desc_id), tx_thi_now, tx_tab_now, 1'b0, tx_tx_stall_abort_now,
            4'h0, tx_channel_number};
        end
        if (tx_tx_stall_abort_now) begin
          tx_append_abort <= 1'b1;
          tx_append_channel_number <= tx_channel_number;
        end
      end
    end
  end

  // Output vector register; data hold until the queue writer takes them
  always @(posedge aclk) begin
    if (!aresetn) begin
      vec_valid <= 1'b0;
      vec_data <= 32'h0000_0000;
    end else if (load) begin
      vec_valid <= g_any_rx || g_tx;
      if (g_any_rx || g_tx) begin
        vec_data <= sel_vec;
      end
    end
  end

  event_counter #(
    .W(16)
  ) u_rx_count (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .inc(g_any_rx),
    .clr(wr_count),
    .count(rx_count)
  );

  event_counter #(
    .W(16)
  ) u_tx_count (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .inc(g_tx),
    .clr(wr_count),
    .count(tx_count)
  );

endmodule

/* File: irq_vector_regs.vh */
/*
  Register offsets, field positions, reset values and vector layout
  for the channel interrupt vector generator.
  Assumes inclusion by bare name from the design files; definitions only.
*/
`ifndef IRQ_VECTOR_REGS_VH
`define IRQ_VECTOR_REGS_VH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_CMD 8'h04
`define OFS_MAXLEN 8'h08
`define OFS_COUNT 8'h0c
`define OFS_PENDING 8'h10

// Control register fields and reset value
`define CTRL_EN_BIT 0
`define CTRL_RXQ_LSB 8
`define CTRL_TXQ_LSB 12
`define CTRL_RESET 32'h0000_1001

// Command register fields
`define CMD_ABORT_BIT 8

// Max length register fields
`define MAXLEN_CHANNEL_NUMBER_LSB 16
`define MAXLEN_DEFAULT 16'h0640

// Vector layout, low half
`define V_NOTIFY 15
`define V_ABORT 14
`define V_FE 13
`define V_STALL 12
`define V_MFL 11
`define V_OVF 10
`define V_CRC 9
`define V_BAD_BIT_LENGTH 8

// Vector layout, high half
`define V_DIR 31
`define V_QUEUE_LSB 24
`define V_TAG_LSB 16

// AXI responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

/* File: event_counter.v */
/*
  Saturating event counter with synchronous clear.
  Assumes one clock, synchronous active-low reset and a clock enable.
*/
`timescale 1ns/1ps
module event_counter #(
  parameter W = 16
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  input wire ce,
  // Control
  input wire inc,
  input wire clr,
  // Value
  output reg [W-1:0] count
);

  // Clear wins so software sees a clean start; saturates instead of wrapping
  always @(posedge aclk) begin
    if (!aresetn) begin
      count <= {W{1'b0}};
    end else if (ce) begin
      if (clr) begin
        count <= {W{1'b0}};
      end else if (inc && count != {W{1'b1}}) begin
        count <= count + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

/* File: maxlen_mem.v */
/*
  Per-channel maximum frame length table, one write and one read port.
  Read data come out of a register one cycle after the address.
  Assumes the writer and reader share the clock.
*/
`timescale 1ns/1ps
`include "irq_vector_regs.vh"
module maxlen_mem #(
  parameter AW = 8,
  parameter DW = 16
) (
  // Clock
  input wire aclk,
  input wire ce,
  // Write port
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [DW-1:0] wdata,
  // Read port
  input wire [AW-1:0] raddr,
  output reg [DW-1:0] rdata
);

  reg [DW-1:0] mem [0:(1<<AW)-1];
  integer i;

  // Table holds no reset; start every channel at the default length
  initial begin
    for (i = 0; i < (1<<AW); i = i + 1) begin
      mem[i] = `MAXLEN_DEFAULT;
    end
  end

  // Registered read, write-first is not needed here
  always @(posedge aclk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end

endmodule

/* File: irq_vec_monitor.sv */
/*
  Port checker for the channel interrupt vector generator.
  Assumes the single clock aclk, synchronous active-low aresetn, ce held high.
*/
`timescale 1ns/1ps
module irq_vec_monitor (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Register bus
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // Transmit side
  input wire tx_ready,
  input wire tx_data_done,
  input wire tx_append_abort,
  // Vector channel
  input wire [31:0] vec_data,
  input wire vec_valid,
  input wire vec_ready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Steps: both write halves taken at one edge; a vector offered but not taken
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence vec_waiting;
    vec_valid && !vec_ready;
  endsequence

  a_vec_hold: assert property (vec_waiting |=> vec_valid && $stable(vec_data))
    else $error("vector changed before taken");
  a_tx_layout: assert property (vec_valid && vec_data[31] |->
    vec_data[13] == 1'b0 && vec_data[11:8] == 4'h0) else $error("tx vector spare bits set");
  a_spare_zero: assert property (vec_valid |-> vec_data[30:27] == 4'h0 && vec_data[23:22] == 2'b00)
    else $error("vector upper spare bits set");
  a_append_once: assert property (tx_append_abort |=> !tx_append_abort)
    else $error("append pulse longer than one cycle");
  a_append_cause: assert property (tx_append_abort |-> $past(tx_data_done) && $past(tx_ready))
    else $error("append pulse without data section done");
  a_b_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_aw_refuse: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("write address accepted twice");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule

bind channel_irq_vector_gen irq_vec_monitor mon (.*);

/* File: vec_sink.sv */
/*
  Host memory side of the vector channel: queues every vector taken.
  Assumes the bench reads got and sets slow to make it answer late.
*/
`timescale 1ns/1ps
module vec_sink (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Vector channel
  input wire [31:0] vec_data,
  input wire vec_valid,
  output reg vec_ready,
  // Pace control
  input wire slow
);
  logic [31:0] got[$];

  // Slow mode accepts every other cycle, so the block must hold its offer
  always @(posedge aclk) begin
    if (!aresetn) begin
      vec_ready <= 1'b0;
    end else begin
      vec_ready <= slow ? !vec_ready : 1'b1;
      if (vec_valid && vec_ready) got.push_back(vec_data);
    end
  end
endmodule

/* File: testbench.sv */
/*
  Self-checking bench for the channel interrupt vector generator.
  Assumes the host side model vec_sink and the bound port checker.
*/
`timescale 1ns/1ps
`include "irq_vector_regs.vh"
module testbench;
  // Drives, all with a value at time zero
  logic aclk = 0, aresetn = 0, ce = 1, slow = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, rx_channel_number = 0, tx_channel_number = 0, app_channel_number = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic rx_frame_done = 0, rx_desc_notify = 0, rx_line_abort = 0, rx_packet_start = 0;
  logic rx_desc_stall = 0, rx_overflow_start = 0, rx_buf_can_store = 1;
  logic [15:0] rx_bit_count = 0, rx_crc_calc = 16'h1234, rx_crc_recv = 16'h1234;
  logic [5:0] tx_desc_id = 0;
  logic tx_desc_done = 0, tx_desc_notify = 0, tx_abort_cmd = 0, tx_fetch = 0, tx_fetch_zero_count = 0;
  logic tx_fetch_fe = 0, tx_fetch_stall = 0, tx_prev_incomplete = 1, tx_data_done = 0;
  // Design outputs
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_ready, tx_ready;
  wire tx_append_abort, vec_valid, vec_ready;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, vec_data;
  wire [7:0] tx_append_channel_number;
  integer errors = 0, n_checks = 0;

  channel_irq_vector_gen uut (.*);
  vec_sink sink (.aclk(aclk), .aresetn(aresetn), .vec_data(vec_data), .vec_valid(vec_valid),
    .vec_ready(vec_ready), .slow(slow));

  // Clock, 40 ns period
  initial forever #20 aclk = ~aclk;
  // Remember which channel the append pulse named
  always @(posedge aclk) if (tx_append_abort) app_channel_number <= tx_append_channel_number;

  task chk(input string what, input [31:0] exp, input [31:0] got);
    begin
      n_checks++;
      if (got !== exp) begin
        errors++;
        $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
    end
  endtask

  task close_out;
    begin
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask

  // One bus access; ready comes late on purpose so the slave must hold its answer
  task axi(input wr, input [7:0] a, input [31:0] d, input [1:0] er, input [31:0] ed);
    integer k;
    logic done;
    begin
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= wr;
      s_axi_wvalid <= wr;
      s_axi_arvalid <= !wr;
      done = 0;
      // No limit of its own; a lost answer is left to the watchdog
      for (k = 0; !done; k++) begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 0;
        if (s_axi_wready) s_axi_wvalid <= 0;
        if (s_axi_arready) s_axi_arvalid <= 0;
        if (k == 3) s_axi_bready <= wr;
        if (k == 3) s_axi_rready <= !wr;
        if (k > 3 && (wr ? s_axi_bvalid : s_axi_rvalid)) begin
          s_axi_bready <= 0;
          s_axi_rready <= 0;
          chk("resp", er, wr ? s_axi_bresp : s_axi_rresp);
          if (!wr) chk("rdata", ed, s_axi_rdata);
          done = 1;
        end
      end
    end
  endtask

  // Hold raised event pulses until the matching ready is sampled, then drop them
  task take(input t);
    integer k;
    begin
      k = 0;
      do begin
        @(posedge aclk);
        k++;
      end while (!(t ? tx_ready : rx_ready) && k < 40);
      {rx_frame_done, rx_packet_start, rx_overflow_start} <= 3'b000;
      {tx_desc_done, tx_abort_cmd, tx_fetch, tx_data_done} <= 4'h0;
    end
  endtask

  task expv(input [31:0] e);
    integer k;
    begin
      for (k = 0; k < 40 && sink.got.size() == 0; k++) @(posedge aclk);
      chk("vector", e, sink.got.size() ? sink.got.pop_front() : 32'hx);
    end
  endtask

  task rx_frame(input [7:0] c, input [15:0] b, input bad, input ab, input nt, input [15:0] mx);
    begin
      rx_channel_number <= c;
      rx_bit_count <= b;
      rx_crc_recv <= bad ? 16'h1235 : 16'h1234;
      rx_line_abort <= ab;
      rx_desc_notify <= nt;
      rx_frame_done <= 1;
      take(0);
      expv({16'h0000, nt, ab, !ab, 1'b0, (b >> 3) > mx, 1'b0, bad && !ab, b[2:0] != 3'h0, c});
    end
  endtask

  task tx_ev(input [6:0] ev, input [7:0] fl);
    begin
      {tx_desc_done, tx_desc_notify, tx_abort_cmd, tx_fetch, tx_fetch_zero_count, tx_fetch_stall, tx_data_done} <= ev;
      take(1);
      if (fl != 8'h00) expv({8'h81, 2'b00, tx_desc_id, fl, tx_channel_number});
    end
  endtask

  task t_regs;
    begin
      axi(0, `OFS_CTRL, 0, `RESP_OKAY, 32'h0000_1001);
      axi(1, `OFS_CTRL, 32'hffff_fffe, `RESP_OKAY, 0);
      axi(0, `OFS_CTRL, 0, `RESP_OKAY, 32'h0000_7700);
      chk("ready", 0, {rx_ready, tx_ready});
      axi(1, `OFS_CTRL, `CTRL_RESET, `RESP_OKAY, 0);
      axi(1, `OFS_MAXLEN, 32'h0005_0004, `RESP_OKAY, 0);
      axi(0, 8'h20, 0, `RESP_SLVERR, 0);
      axi(1, 8'h14, 0, `RESP_SLVERR, 0);
    end
  endtask

  task t_rx;
    begin
      rx_frame(8'h05, 16'd40, 0, 0, 1, 16'h0004);
      rx_frame(8'h05, 16'd32, 0, 0, 0, 16'h0004);
      rx_frame(8'h06, 16'd41, 1, 0, 0, 16'h0640);
      rx_frame(8'h07, 16'd48, 1, 1, 0, 16'h0640);
      axi(1, `OFS_CMD, 32'h0000_0133, `RESP_OKAY, 0);
      expv(32'h0000_4033);
    end
  endtask

  task t_discard;
    integer i;
    begin
      rx_channel_number <= 8'h09;
      rx_desc_stall <= 1;
      for (i = 0; i < 3; i++) begin
        rx_packet_start <= 1;
        take(0);
        expv({16'h0000, i ? 8'h50 : 8'h10, 8'h09});
      end
      rx_desc_stall <= 0;
    end
  endtask

  task t_overflow;
    begin
      rx_channel_number <= 8'h0b;
      rx_buf_can_store <= 0;
      rx_overflow_start <= 1;
      take(0);
      repeat (10) @(posedge aclk);
      chk("queue", 0, 32'(sink.got.size()));
      rx_buf_can_store <= 1;
      expv(32'h0000_040b);
    end
  endtask

  task t_tx;
    begin
      slow <= 1;
      tx_channel_number <= 8'h81;
      tx_desc_id <= 6'h2a;
      tx_ev(7'b1100000, 8'h80);
      tx_ev(7'b0010000, 8'h40);
      tx_ev(7'b0001100, 8'h40);
      slow <= 0;
      tx_channel_number <= 8'hc3;
      tx_ev(7'b0001010, 8'h00);
      repeat (10) @(posedge aclk);
      chk("queue", 0, 32'(sink.got.size()));
      axi(0, `OFS_PENDING, 0, `RESP_OKAY, 32'h0000_0008);
      tx_ev(7'b0000001, 8'h10);
      chk("append", 8'hc3, app_channel_number);
      axi(0, `OFS_COUNT, 0, `RESP_OKAY, 32'h0004_0009);
      axi(1, `OFS_COUNT, 0, `RESP_OKAY, 0);
      axi(0, `OFS_COUNT, 0, `RESP_OKAY, 0);
    end
  endtask

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_regs;
    t_rx;
    t_discard;
    t_overflow;
    t_tx;
    close_out;
  end

  // Cut a hang short
  initial begin
    #(40 * 6000);
    errors++;
    close_out;
  end
endmodule
